/* bit_sync.sv */
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stage1_q <= '0;
      sync_out <= '0;
    end else begin
      stage1_q <= async_in;
      sync_out <= stage1_q;
    end
  end

endmodule // bit_sync

/* host_view.sv */
// Upstream host view of the hub: visible ports and reported current
`timescale 1ns/1ns
module host_view (
  input  wire logic [6:1] port_logical_num,
  input  wire logic [7:0] descriptor_max_power,
  output logic      [1:0] host_ports,
  output logic      [8:0] host_ma
);
  // A port with logical number zero is never enumerated
  always_comb host_ports = 2'(|port_logical_num[2:1]) + 2'(|port_logical_num[4:3])
                         + 2'(|port_logical_num[6:5]);
  always_comb host_ma = {descriptor_max_power, 1'b0};
endmodule // host_view

/* hub_cfg_asserts.sv */
// Checker on the port and power outputs of the configuration bank
`timescale 1ns/1ns
module hub_cfg_asserts #(
  parameter int PORTS = 3
) (
  input wire logic               mclk,
  input wire logic               sys_rst,
  input wire logic [PORTS:1]     port_enabled,
  input wire logic [2*PORTS:1]   port_logical_num,
  input wire logic [1:0]         enabled_port_count,
  input wire logic [7:0]         descriptor_max_power,
  input wire logic               numbering_custom
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_CNT: assert property (enabled_port_count == $countones(port_enabled))
    else $error("enabled count differs from enabled ports");
  AST_HIDE: assert property (port_enabled == {|port_logical_num[6:5], |port_logical_num[4:3],
    |port_logical_num[2:1]}) else $error("hidden port has a number");
  AST_P1: assert property (port_enabled[1] |-> port_logical_num[2:1] == 2'h1)
    else $error("port 1 not numbered first");
  AST_P2: assert property (port_enabled[2] |-> port_logical_num[4:3] == 2'h1 + port_enabled[1])
    else $error("port 2 number not contiguous");
  AST_P3: assert property (port_enabled[3] |-> port_logical_num[6:5] == enabled_port_count)
    else $error("port 3 number not contiguous");
  AST_RANGE: assert property (port_logical_num[4:3] <= enabled_port_count)
    else $error("port 2 number beyond count");
  AST_CUSTOM: assert property (numbering_custom && $past(numbering_custom) |->
    port_enabled == 3'h7 && port_logical_num == 6'h39) else $error("custom numbering not identity");
  AST_RSTPWR: assert property (disable iff (1'b0) sys_rst |=>
    descriptor_max_power == 8'h32 && port_enabled == 3'h0) else $error("power byte wrong after reset");
endmodule // hub_cfg_asserts
bind hub_port_disable_power_cfg hub_cfg_asserts #(.PORTS(PORTS)) u_hub_cfg_asserts (
  .mclk(mclk), .sys_rst(sys_rst), .port_enabled(port_enabled), .port_logical_num(port_logical_num),
  .enabled_port_count(enabled_port_count), .descriptor_max_power(descriptor_max_power),
  .numbering_custom(numbering_custom));

/* hub_cfg_pkg.sv */
// Constants shared by the port-disable and max-power configuration bank
package hub_cfg_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [9:0] IDX_PORT_OFF_SP  = 10'h0E8;
  localparam logic [9:0] IDX_PORT_OFF_BP  = 10'h0E9;
  localparam logic [9:0] IDX_MAX_CUR_SP   = 10'h0EA;
  localparam logic [9:0] IDX_MAX_CUR_BP   = 10'h0EB;
  localparam logic [9:0] IDX_CTRL         = 10'h0F8;
  localparam logic [9:0] IDX_STATUS       = 10'h0F9;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PORT_LO          = 1;
  localparam int PORT_HI          = 3;
  localparam int NUM_PORTS        = 3;
  localparam int CTRL_CUSTOM_BIT  = 0;
  localparam int CTRL_STRAP_BIT   = 1;
  localparam int STAT_SELF_BIT    = 0;
  localparam int STAT_EN_LO       = 1;
  localparam int STAT_CNT_LO      = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_PORT_OFF     = 8'h00;
  localparam logic [7:0] RST_MAX_CUR      = 8'h32;
  localparam logic [1:0] RST_CTRL         = 2'h0;

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  // Last settle count before the strap pins are caught
  localparam logic [1:0] STRAP_SETTLE_LAST = 2'h2;

endpackage

/* hub_port_disable_power_cfg.sv */
// Port-disable masks, max-power bytes and port renumbering for the hub
//
// Function
// - A mask bit at one disables its downstream port and a zero leaves it available.
// - A disabled port is hidden from the host and cannot be enabled or enumerated while configured so.
// - Any mix of disabled ports is accepted and the count of enabled ports is reported exactly.
// - The remaining active ports are renumbered contiguously for the host.
// - Mask bits 3 to 1 govern physical ports 3 to 1 and bits 7 to 4 and 0 have no port effect.
// - In self-powered operation the self-powered mask selects the disabled ports.
// - In bus-powered operation a separate bus-powered mask selects the disabled ports.
// - With control bit 1 (the strap bit) set and custom numbering off, the two strap pins select the disabled ports.
// - The self-powered max-power byte counts in 2 mA steps for self-powered operation.
// - The bus-powered max-power byte, also in 2 mA steps, is reported while bus-powered.
// - Masks and contiguous renumbering apply only when custom numbering is off.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
module hub_port_disable_power_cfg
  import hub_cfg_pkg::*;
#(
  parameter int PORTS = NUM_PORTS
) (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Pins
  input  wire logic                self_powered,
  input  wire logic [1:0]          port_off_strap_pins,
  // Toward the hub core
  output logic      [PORTS:1]      port_enabled,
  output logic      [2*PORTS:1]    port_logical_num,
  output logic      [1:0]          enabled_port_count,
  output logic      [7:0]          descriptor_max_power,
  output logic                     numbering_custom
);

  // ****************************************************************
  // Pin synchronisers and strap capture
  // ****************************************************************
  logic       self_powered_s;
  logic [1:0] strap_s;
  logic [1:0] strap_q;

  bit_sync #(.WIDTH(3)) u_pin_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in ({self_powered, port_off_strap_pins}),
    .sync_out ({self_powered_s, strap_s})
  );

  // Straps are caught once after reset, once the synchroniser has settled;
  // later pin movement is ignored so the port set cannot shift under the host
  typedef enum logic [1:0] {
    STRAP_SETTLE = 2'b00,
    STRAP_SAMPLE = 2'b01,
    STRAP_HELD   = 2'b11
  } strap_state_e;

  strap_state_e strap_state_q;
  logic [1:0]   strap_wait_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      strap_state_q <= STRAP_SETTLE;
      strap_wait_q  <= 2'h0;
    end else begin
      case (strap_state_q)
        STRAP_SETTLE: begin
          strap_wait_q <= strap_wait_q + 2'h1;
          if (strap_wait_q == STRAP_SETTLE_LAST) begin
            strap_state_q <= STRAP_SAMPLE;
          end
        end
        STRAP_SAMPLE: strap_state_q <= STRAP_HELD;
        STRAP_HELD:   strap_state_q <= STRAP_HELD;
        default:      strap_state_q <= STRAP_SETTLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      strap_q <= 2'h0;
    end else if (strap_state_q == STRAP_SAMPLE) begin
      strap_q <= strap_s;
    end
  end

  // ****************************************************************
  // APB register bank
  // ****************************************************************
  logic [7:0] port_off_mask_self_powered_q;
  logic [7:0] port_off_mask_bus_powered_q;
  logic [7:0] max_current_self_powered_q;
  logic [7:0] max_current_bus_powered_q;
  logic [1:0] ctrl_q;

  logic [9:0] word_idx;
  logic       setup_phase;
  logic       wr_commit;
  logic       idx_known;
  logic [7:0] wr_byte;

  assign word_idx    = paddr[11:2];
  assign setup_phase = psel && !penable;
  assign wr_commit   = psel && penable && pready && pwrite && !pslverr;
  assign wr_byte     = pstrb[0] ? pwdata[7:0] : 8'h00;

  always_comb begin
    case (word_idx)
      IDX_PORT_OFF_SP,
      IDX_PORT_OFF_BP,
      IDX_MAX_CUR_SP,
      IDX_MAX_CUR_BP,
      IDX_CTRL,
      IDX_STATUS:      idx_known = 1'b1;
      default:         idx_known = 1'b0;
    endcase
  end

  // ****************************************************************
  // Register write decode
  // ****************************************************************
  logic wr_off_sp;
  logic wr_off_bp;
  logic wr_cur_sp;
  logic wr_cur_bp;
  logic wr_ctrl;

  // A cleared byte strobe leaves the register untouched
  assign wr_off_sp = wr_commit && pstrb[0] && (word_idx == IDX_PORT_OFF_SP);
  assign wr_off_bp = wr_commit && pstrb[0] && (word_idx == IDX_PORT_OFF_BP);
  assign wr_cur_sp = wr_commit && pstrb[0] && (word_idx == IDX_MAX_CUR_SP);
  assign wr_cur_bp = wr_commit && pstrb[0] && (word_idx == IDX_MAX_CUR_BP);
  assign wr_ctrl   = wr_commit && pstrb[0] && (word_idx == IDX_CTRL);

  // All eight bits are kept; only bits 3..1 of a mask reach the ports
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      port_off_mask_self_powered_q <= RST_PORT_OFF;
    end else if (wr_off_sp) begin
      port_off_mask_self_powered_q <= wr_byte;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      port_off_mask_bus_powered_q <= RST_PORT_OFF;
    end else if (wr_off_bp) begin
      port_off_mask_bus_powered_q <= wr_byte;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      max_current_self_powered_q <= RST_MAX_CUR;
    end else if (wr_cur_sp) begin
      max_current_self_powered_q <= wr_byte;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      max_current_bus_powered_q <= RST_MAX_CUR;
    end else if (wr_cur_bp) begin
      max_current_bus_powered_q <= wr_byte;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= wr_byte[1:0];
    end
  end

  // ****************************************************************
  // Disabled-port selection
  // ****************************************************************
  logic [PORTS:1] off_sel;
  logic [PORTS:1] strap_mask;
  logic [PORTS:1] on_next;
  logic [2*PORTS:1] num_next;
  logic [1:0]     cnt_next;

  // Strap pin 0 disables port 1, strap pin 1 disables port 2; no pin reaches port 3
  genvar port_i;
  generate
    for (port_i = 1; port_i <= PORTS; port_i++) begin : g_strap
      if (port_i <= 2) begin : g_pin
        assign strap_mask[port_i] = strap_q[port_i-1];
      end else begin : g_no_pin
        assign strap_mask[port_i] = 1'b0;
      end
    end
  endgenerate

  // Where the port-off set comes from; custom numbering wins, then straps
  typedef enum logic [1:0] {
    SRC_BUS_MASK  = 2'b00,
    SRC_SELF_MASK = 2'b01,
    SRC_STRAP     = 2'b11,
    SRC_CUSTOM    = 2'b10
  } off_src_e;

  off_src_e off_src;

  always_comb begin
    if (ctrl_q[CTRL_CUSTOM_BIT]) begin
      off_src = SRC_CUSTOM;
    end else if (ctrl_q[CTRL_STRAP_BIT]) begin
      off_src = SRC_STRAP;
    end else if (self_powered_s) begin
      off_src = SRC_SELF_MASK;
    end else begin
      off_src = SRC_BUS_MASK;
    end
  end

  always_comb begin
    case (off_src)
      SRC_CUSTOM:    off_sel = '0;
      SRC_STRAP:     off_sel = strap_mask;
      SRC_SELF_MASK: off_sel = port_off_mask_self_powered_q[PORT_HI:PORT_LO];
      SRC_BUS_MASK:  off_sel = port_off_mask_bus_powered_q[PORT_HI:PORT_LO];
      default:       off_sel = port_off_mask_bus_powered_q[PORT_HI:PORT_LO];
    endcase
  end

  port_renumber #(.PORTS(PORTS)) u_renumber (
    .port_off      (off_sel),
    .port_on       (on_next),
    .logical_num   (num_next),
    .enabled_count (cnt_next)
  );

  // ****************************************************************
  // Outputs to the hub core
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      port_enabled       <= '0;
      port_logical_num   <= '0;
      enabled_port_count <= 2'h0;
    end else begin
      port_enabled       <= on_next;
      port_logical_num   <= num_next;
      enabled_port_count <= cnt_next;
    end
  end

  // ****************************************************************
  // Power byte for the descriptor
  // ****************************************************************
  logic [7:0] mode_max_current;

  // Units stay 2 mA; the hub core scales when it builds the descriptor
  always_comb begin
    if (self_powered_s) begin
      mode_max_current = max_current_self_powered_q;
    end else begin
      mode_max_current = max_current_bus_powered_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      descriptor_max_power <= RST_MAX_CUR;
    end else begin
      descriptor_max_power <= mode_max_current;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      numbering_custom <= 1'b0;
    end else begin
      numbering_custom <= ctrl_q[CTRL_CUSTOM_BIT];
    end
  end

  // ****************************************************************
  // Read data and handshake
  // ****************************************************************
  logic [31:0] status_word;
  logic        access_refused;
  logic [31:0] rd_mux;

  // Read-only view of the live selection, for software that cannot see the hub core
  always_comb begin
    status_word                      = 32'h0000_0000;
    status_word[STAT_SELF_BIT]       = self_powered_s;
    status_word[STAT_EN_LO +: PORTS] = port_enabled;
    status_word[STAT_CNT_LO +: 2]    = enabled_port_count;
  end

  // Unknown words and writes to the status word are refused with no side effect
  assign access_refused = !idx_known || (pwrite && (word_idx == IDX_STATUS));

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (word_idx)
      IDX_PORT_OFF_SP: rd_mux[7:0] = port_off_mask_self_powered_q;
      IDX_PORT_OFF_BP: rd_mux[7:0] = port_off_mask_bus_powered_q;
      IDX_MAX_CUR_SP:  rd_mux[7:0] = max_current_self_powered_q;
      IDX_MAX_CUR_BP:  rd_mux[7:0] = max_current_bus_powered_q;
      IDX_CTRL:        rd_mux[1:0] = ctrl_q;
      IDX_STATUS:      rd_mux      = status_word;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // One wait-free access phase: ready rises for the cycle after setup
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      pready  <= 1'b1;
      pslverr <= access_refused;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Read data is held until the next setup so a slow master still sees it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata <= (pwrite || access_refused) ? 32'h0000_0000 : rd_mux;
    end
  end

endmodule // hub_port_disable_power_cfg

/* hub_port_disable_power_cfg_bench.sv */
// Self-checking bench for the port-disable and max-power bank
`timescale 1ns/1ns
module hub_port_disable_power_cfg_bench;
  import hub_cfg_pkg::*;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, self_powered, numbering_custom, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb;
  logic [1:0]  port_off_strap_pins, enabled_port_count, host_ports;
  logic [3:1]  port_enabled;
  logic [6:1]  port_logical_num;
  logic [7:0]  descriptor_max_power;
  logic [8:0]  host_ma;
  logic [10:0] obs;
  int          n_errors, n_compared, cyc;
  assign obs = {port_logical_num, port_enabled, enabled_port_count};
  hub_port_disable_power_cfg u_hub_port_disable_power_cfg (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .self_powered(self_powered),
    .port_off_strap_pins(port_off_strap_pins), .port_enabled(port_enabled),
    .port_logical_num(port_logical_num), .enabled_port_count(enabled_port_count),
    .descriptor_max_power(descriptor_max_power), .numbering_custom(numbering_custom));
  host_view u_host_view (.port_logical_num(port_logical_num), .descriptor_max_power(descriptor_max_power),
    .host_ports(host_ports), .host_ma(host_ma));
  always #5 mclk = ~mclk;
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge mclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) n_errors++;
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask
  // Expected {numbers, enables, count} from a set of disabled ports
  function automatic logic [10:0] expv(input logic [3:1] off);
    logic [1:0] k;
    logic [6:1] nm;
    k = 2'h0;
    nm = 6'h00;
    for (int p = 1; p <= 3; p++) if (!off[p]) begin
      k++;
      nm[2*p-:2] = k;
    end
    return {nm, ~off, k};
  endfunction
  task automatic close_out;
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, IDX_PORT_OFF_SP + 10'(i), 32'h0);
      chk("reset value", rdat, i < 2 ? 32'h0 : 32'h32);
    end
    apb(1'b0, IDX_CTRL, 32'h0);
    chk("ctrl reset", rdat, 32'h0);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("status read", rdat, 32'h3F);
    apb(1'b0, 10'h100, 32'h0);
    chk("unmapped read", rdat, 32'h0);
    chk("unmapped error", rerr, 1'b1);
    apb(1'b1, IDX_STATUS, 32'hFF);
    chk("status write", rerr, 1'b1);
    pstrb <= 4'hE;
    apb(1'b1, IDX_MAX_CUR_BP, 32'h11);
    pstrb <= 4'hF;
    apb(1'b0, IDX_MAX_CUR_BP, 32'h0);
    chk("masked write", rdat, 32'h32);
  endtask
  task automatic t_self;
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, IDX_PORT_OFF_SP, {24'h0, 4'hF, 3'(m), 1'b1});
      apb(1'b1, IDX_PORT_OFF_BP, {28'h0, ~3'(m), 1'b0});
      settle(2);
      chk("self mask", obs, expv(3'(m)));
      chk("host ports", host_ports, expv(3'(m)) & 11'h3);
      apb(1'b0, IDX_PORT_OFF_SP, 32'h0);
      chk("mask readback", rdat, {24'h0, 4'hF, 3'(m), 1'b1});
    end
  endtask
  task automatic t_power;
    // 84 mA and 30 mA, both inside the 100 mA ceiling
    apb(1'b1, IDX_MAX_CUR_SP, 32'h2A);
    apb(1'b1, IDX_MAX_CUR_BP, 32'h0F);
    apb(1'b1, IDX_PORT_OFF_BP, 32'h04);
    self_powered <= 1'b0;
    settle(6);
    chk("bus mask", obs, expv(3'b010));
    chk("bus power", host_ma, 9'd30);
    @(posedge mclk);
    self_powered <= 1'b1;
    settle(6);
    chk("self mask back", obs, expv(3'b111));
    chk("self power", host_ma, 9'd84);
  endtask
  task automatic t_modes;
    apb(1'b1, IDX_CTRL, 32'h2);
    settle(2);
    chk("strap pins", obs, expv(3'b010));
    chk("custom flag off", numbering_custom, 1'b0);
    apb(1'b1, IDX_CTRL, 32'h3);
    settle(2);
    chk("custom numbering", obs, {6'h39, 3'h7, 2'h3});
    chk("custom flag on", numbering_custom, 1'b1);
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      close_out;
    end
  end
  initial begin
    {mclk, psel, penable, pwrite, paddr, pwdata, n_errors, n_compared, cyc} = '0;
    sys_rst = 1'b1;
    pstrb = 4'hF;
    self_powered = 1'b1;
    // Straps must hold still from reset until captured
    port_off_strap_pins = 2'h2;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    settle(6);
    t_regs;
    t_self;
    t_power;
    t_modes;
    close_out;
  end
endmodule // hub_port_disable_power_cfg_bench

/* port_renumber.sv */
// Contiguous renumbering of the downstream ports left enabled
`timescale 1ns/1ns
module port_renumber #(
  parameter int PORTS = 3
) (
  input  wire logic [PORTS:1]   port_off,
  output logic      [PORTS:1]   port_on,
  output logic      [2*PORTS:1] logical_num,
  output logic      [1:0]       enabled_count
);

  // Running count of enabled ports up to and including each position
  logic [1:0] prefix [0:PORTS];

  assign prefix[0] = 2'h0;

  genvar p;
  generate
    for (p = 1; p <= PORTS; p++) begin : g_port
      assign port_on[p]   = ~port_off[p];
      assign prefix[p]    = prefix[p-1] + {1'b0, port_on[p]};
      // Hidden ports report logical number zero
      assign logical_num[2*p -: 2] = port_on[p] ? prefix[p] : 2'h0;
    end
  endgenerate

  assign enabled_count = prefix[PORTS];

endmodule // port_renumber
